// ---- verilog/pspm_monitor.sv ----
// Stream performance monitor top: period timer, tag and published counts.
`timescale 1ns/1ps
`include "pspm_params.svh"
module pspm_monitor #(
   parameter int unsigned SECOND_CYCLES = `PSPM_SECOND_CYCLES
) (
   input  wire logic         ref_clk,
   input  wire logic         rstn,
   input  wire logic         ce,
   input  wire logic [127:0] s_axis_tx_tdata,
   input  wire logic         s_axis_tx_tlast,
   input  wire logic         s_axis_tx_tvalid,
   input  wire logic         s_axis_tx_tready,
   input  wire logic [127:0] m_axis_rx_tdata,
   input  wire logic         m_axis_rx_tlast,
   input  wire logic         m_axis_rx_tvalid,
   input  wire logic         m_axis_rx_tready,
   output logic      [31:0]  tx_byte_count,
   output logic      [31:0]  rx_byte_count,
   output logic      [31:0]  tx_payload_count,
   output logic      [31:0]  rx_payload_count
);

   localparam logic [`PSPM_TIMER_W-1:0] TIMER_LAST = `PSPM_TIMER_W'(SECOND_CYCLES - 1);

   logic [`PSPM_TIMER_W-1:0] timer;
   logic [`PSPM_TIMER_W-1:0] next_timer;
   logic [1:0]               tag;
   logic [1:0]               next_tag;
   logic                     snap;
   logic                     seen_snap;
   logic                     next_seen_snap;
   logic [31:0]              tx_raw_sum;
   logic [31:0]              tx_pay_sum;
   logic [31:0]              rx_raw_sum;
   logic [31:0]              rx_pay_sum;
   logic [31:0]              next_tx_byte;
   logic [31:0]              next_rx_byte;
   logic [31:0]              next_tx_pay;
   logic [31:0]              next_rx_pay;

   // ====================================================================
   // Per-direction accumulators
   // Only the header word of each beat matters; the rest of the data bus is
   // watched for nothing, so it is never driven and never stored.
   pspm_dir_counter u_tx (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .ce      (ce),
      .tvalid  (s_axis_tx_tvalid),
      .tready  (s_axis_tx_tready),
      .tlast   (s_axis_tx_tlast),
      .hdr     (s_axis_tx_tdata[31:0]),
      .snap    (snap),
      .raw_sum (tx_raw_sum),
      .pay_sum (tx_pay_sum)
   );

   pspm_dir_counter u_rx (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .ce      (ce),
      .tvalid  (m_axis_rx_tvalid),
      .tready  (m_axis_rx_tready),
      .tlast   (m_axis_rx_tlast),
      .hdr     (m_axis_rx_tdata[31:0]),
      .snap    (snap),
      .raw_sum (rx_raw_sum),
      .pay_sum (rx_pay_sum)
   );

   // ====================================================================
   // Period timer, tag and snapshot values
   // The snapshot takes the sum including the current beat, so the beat
   // on the last cycle of a period is neither lost nor counted twice.
   always_comb begin
      snap           = ce && (timer == TIMER_LAST);
      next_timer     = (timer == TIMER_LAST) ? '0 : timer + `PSPM_TIMER_W'(1);
      next_tag       = (timer == TIMER_LAST) ? tag + `PSPM_TAG_STEP : tag;
      next_seen_snap = seen_snap || (timer == TIMER_LAST);
      next_tx_byte   = tx_byte_count;
      next_rx_byte   = rx_byte_count;
      next_tx_pay    = tx_payload_count;
      next_rx_pay    = rx_payload_count;
      if (timer == TIMER_LAST) begin
         next_tx_byte = {tx_raw_sum[31:2], next_tag};
         next_rx_byte = {rx_raw_sum[31:2], next_tag};
         next_tx_pay  = {tx_pay_sum[31:2], next_tag};
         next_rx_pay  = {rx_pay_sum[31:2], next_tag};
      end
   end

   // ====================================================================
   // Registers
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         timer            <= '0;
         tag              <= `PSPM_TAG_RST;
         seen_snap        <= 1'b0;
         tx_byte_count    <= `PSPM_CNT_RST;
         rx_byte_count    <= `PSPM_CNT_RST;
         tx_payload_count <= `PSPM_CNT_RST;
         rx_payload_count <= `PSPM_CNT_RST;
      end else if (ce) begin
         timer            <= next_timer;
         tag              <= next_tag;
         seen_snap        <= next_seen_snap;
         tx_byte_count    <= next_tx_byte;
         rx_byte_count    <= next_rx_byte;
         tx_payload_count <= next_tx_pay;
         rx_payload_count <= next_rx_pay;
      end
   end

   // ====================================================================
   // Checks
   // Software sees a tag change as the sign of a fresh sample; a reading
   // with an unchanged tag is stale and must be repeated.
   property p_tag_advance;
      @(posedge ref_clk) disable iff (!rstn)
      snap |=> (tag == $past(tag) + 2'h1);
   endproperty
   a_tag_advance: assert property (p_tag_advance) else $error("tag did not step");

   property p_tag_hold;
      @(posedge ref_clk) disable iff (!rstn)
      !snap |=> $stable(tag);
   endproperty
   a_tag_hold: assert property (p_tag_hold) else $error("tag moved between refreshes");

   property p_pub_hold;
      @(posedge ref_clk) disable iff (!rstn)
      !snap |=> $stable(tx_byte_count) && $stable(rx_byte_count) &&
                $stable(tx_payload_count) && $stable(rx_payload_count);
   endproperty
   a_pub_hold: assert property (p_pub_hold) else $error("published count moved");

   property p_pub_load;
      @(posedge ref_clk) disable iff (!rstn)
      snap |=> (tx_byte_count[31:2] == $past(tx_raw_sum[31:2])) &&
               (rx_payload_count[31:2] == $past(rx_pay_sum[31:2]));
   endproperty
   a_pub_load: assert property (p_pub_load) else $error("snapshot value wrong");

   property p_low_bits;
      @(posedge ref_clk) disable iff (!rstn)
      (tx_byte_count[1:0] == tag) && (rx_byte_count[1:0] == tag) &&
      (tx_payload_count[1:0] == tag) && (rx_payload_count[1:0] == tag);
   endproperty
   a_low_bits: assert property (p_low_bits) else $error("low bits differ from tag");

   property p_zero_before_first;
      @(posedge ref_clk) disable iff (!rstn)
      !seen_snap |-> (tx_byte_count == 32'h0000_0000) && (rx_byte_count == 32'h0000_0000) &&
                     (tx_payload_count == 32'h0000_0000) && (rx_payload_count == 32'h0000_0000);
   endproperty
   a_zero_before_first: assert property (p_zero_before_first) else $error("not zero");

   property p_timer_period;
      @(posedge ref_clk) disable iff (!rstn)
      snap |=> (timer == '0);
   endproperty
   a_timer_period: assert property (p_timer_period) else $error("timer not restarted");

   property p_snap_only_at_end;
      @(posedge ref_clk) disable iff (!rstn)
      (ce && timer != TIMER_LAST) |-> !snap ##1 (timer == $past(timer) + 1'b1);
   endproperty
   a_snap_only_at_end: assert property (p_snap_only_at_end) else $error("timer misstep");

   property p_freeze;
      @(posedge ref_clk) disable iff (!rstn)
      !ce |=> $stable(timer) && $stable(tag) && $stable(tx_byte_count);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with enable low");

   property p_pub_load_rest;
      @(posedge ref_clk) disable iff (!rstn)
      snap |=> (rx_byte_count[31:2] == $past(rx_raw_sum[31:2])) &&
               (tx_payload_count[31:2] == $past(tx_pay_sum[31:2]));
   endproperty
   a_pub_load_rest: assert property (p_pub_load_rest) else $error("snapshot value wrong");

   property p_freeze_rest;
      @(posedge ref_clk) disable iff (!rstn)
      !ce |=> $stable(rx_byte_count) && $stable(tx_payload_count) &&
              $stable(rx_payload_count) && $stable(seen_snap);
   endproperty
   a_freeze_rest: assert property (p_freeze_rest) else $error("output moved frozen");

   property p_seen_set;
      @(posedge ref_clk) disable iff (!rstn)
      snap |=> seen_snap;
   endproperty
   a_seen_set: assert property (p_seen_set) else $error("refresh not recorded");

   property p_tag_zero_first;
      @(posedge ref_clk) disable iff (!rstn)
      !seen_snap |-> (tag == `PSPM_TAG_RST);
   endproperty
   a_tag_zero_first: assert property (p_tag_zero_first) else $error("tag not cleared");

   // The first refresh after reset shows tag 01; later ones step by one.
   property p_first_tag;
      @(posedge ref_clk) disable iff (!rstn)
      (snap && !seen_snap) |=> (tag == 2'h1);
   endproperty
   a_first_tag: assert property (p_first_tag) else $error("first tag wrong");

   property p_tag_wrap;
      @(posedge ref_clk) disable iff (!rstn)
      (snap && tag == 2'h3) |=> (tag == 2'h0);
   endproperty
   a_tag_wrap: assert property (p_tag_wrap) else $error("tag did not wrap");

   // A timer beyond its last count would not refresh again until it wrapped
   // past zero, so it is boxed in here.
   property p_timer_bound;
      @(posedge ref_clk) disable iff (!rstn)
      (timer <= TIMER_LAST);
   endproperty
   a_timer_bound: assert property (p_timer_bound) else $error("timer out of range");

endmodule

// ---- shared/pspm_params.svh ----
// Constants for the stream performance monitor.
// Notes on behaviour
// - Both 128-bit stream directions are observed only, every clock edge with ce high, never driven.
// - Published counts refresh once per second with totals of the period just ended.
// - Each outbound valid-and-ready beat adds its bytes to the raw outbound counter.
// - Each inbound valid-and-ready beat adds its bytes to the raw inbound counter.
// - Outbound memory-write and completion payload bytes add to the outbound payload count.
// - Inbound memory-write and completion payload bytes add to the inbound payload count.
// - Packet start is the first transferred beat after a beat carrying end-of-frame.
// - A beat counts only when valid and ready are both high together.
// - Published counts have four-byte resolution; low two bits carry the period tag.
// - The period tag steps 00, 01, 10, 11, then wraps, each refresh.
// - Only transaction-layer totals are reported; user payload is left to the DMA.
`ifndef PSPM_PARAMS_SVH
`define PSPM_PARAMS_SVH

// ====================================================================
// Timing
`define PSPM_CLK_PERIOD_NS   8
`define PSPM_SECOND_NS       1000000000
`define PSPM_SECOND_CYCLES   (`PSPM_SECOND_NS / `PSPM_CLK_PERIOD_NS)
`define PSPM_TIMER_W         28

// ====================================================================
// Beat and header fields
`define PSPM_BEAT_BYTES      32'h0000_0010
`define PSPM_FMT_DATA_BIT    30
`define PSPM_TYPE_HI         28
`define PSPM_TYPE_LO         24
`define PSPM_LEN_HI          9
`define PSPM_LEN_LO          0
`define PSPM_TYPE_MWR        5'h00
`define PSPM_TYPE_CPLD       5'h0A
`define PSPM_LEN_MAX_DW      11'h400

// ====================================================================
// Reset values
`define PSPM_CNT_RST         32'h0000_0000
`define PSPM_TAG_RST         2'h0
`define PSPM_TAG_STEP        2'h1

`endif

// ---- shared/pspm_pkg.sv ----
// Types shared by the stream performance monitor modules.
package pspm_pkg;

   // ====================================================================
   // Packet phase of one stream direction
   typedef enum logic [0:0] {
      PSPM_PH_START = 1'b0,
      PSPM_PH_BODY  = 1'b1
   } pspm_phase_type;

endpackage

// ---- verilog/pspm_dir_counter.sv ----
// Raw and payload byte accumulators for one stream direction.
`timescale 1ns/1ps
`include "pspm_params.svh"
module pspm_dir_counter (
   input  wire logic        ref_clk,
   input  wire logic        rstn,
   input  wire logic        ce,
   input  wire logic        tvalid,
   input  wire logic        tready,
   input  wire logic        tlast,
   input  wire logic [31:0] hdr,
   input  wire logic        snap,
   output logic      [31:0] raw_sum,
   output logic      [31:0] pay_sum
);

   pspm_pkg::pspm_phase_type phase;
   pspm_pkg::pspm_phase_type next_phase;
   logic [31:0]              raw_acc;
   logic [31:0]              pay_acc;
   logic [31:0]              next_raw_acc;
   logic [31:0]              next_pay_acc;
   logic                     fire;
   logic                     start;
   logic                     pay_type;
   logic [10:0]              len_dw;
   logic [12:0]              pay_bytes;

   // ====================================================================
   // Next-state logic
   always_comb begin
      fire     = tvalid && tready;
      start    = fire && (phase == pspm_pkg::PSPM_PH_START);
      pay_type = hdr[`PSPM_FMT_DATA_BIT] &&
                 ((hdr[`PSPM_TYPE_HI:`PSPM_TYPE_LO] == `PSPM_TYPE_MWR) ||
                  (hdr[`PSPM_TYPE_HI:`PSPM_TYPE_LO] == `PSPM_TYPE_CPLD));
      // A zero length field means the largest payload.
      len_dw = (hdr[`PSPM_LEN_HI:`PSPM_LEN_LO] == 10'h000) ? `PSPM_LEN_MAX_DW
               : {1'b0, hdr[`PSPM_LEN_HI:`PSPM_LEN_LO]};
      pay_bytes = {len_dw, 2'b00};
      raw_sum = fire ? raw_acc + `PSPM_BEAT_BYTES : raw_acc;
      // The whole payload is credited at the header beat, so a discontinued
      // packet is still counted at its declared length.
      pay_sum = (start && pay_type) ? pay_acc + {19'h0_0000, pay_bytes} : pay_acc;
      next_raw_acc = snap ? `PSPM_CNT_RST : raw_sum;
      next_pay_acc = snap ? `PSPM_CNT_RST : pay_sum;
      case (phase)
         pspm_pkg::PSPM_PH_START: begin
            next_phase = (fire && !tlast) ? pspm_pkg::PSPM_PH_BODY : pspm_pkg::PSPM_PH_START;
         end
         pspm_pkg::PSPM_PH_BODY: begin
            next_phase = (fire && tlast) ? pspm_pkg::PSPM_PH_START
                         : pspm_pkg::PSPM_PH_BODY;
         end
         default: begin
            next_phase = pspm_pkg::PSPM_PH_START;
         end
      endcase
   end

   // ====================================================================
   // State registers
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         phase   <= pspm_pkg::PSPM_PH_START;
         raw_acc <= `PSPM_CNT_RST;
         pay_acc <= `PSPM_CNT_RST;
      end else if (ce) begin
         phase   <= next_phase;
         raw_acc <= next_raw_acc;
         pay_acc <= next_pay_acc;
      end
   end

   // ====================================================================
   // Checks
   property p_raw_add;
      @(posedge ref_clk) disable iff (!rstn)
      (ce && tvalid && tready && !snap) |=> (raw_acc == $past(raw_acc) + `PSPM_BEAT_BYTES);
   endproperty
   a_raw_add: assert property (p_raw_add) else $error("raw count missed a beat");

   property p_no_fire_hold;
      @(posedge ref_clk) disable iff (!rstn)
      (ce && !(tvalid && tready) && !snap) |=> $stable(raw_acc) && $stable(pay_acc);
   endproperty
   a_no_fire_hold: assert property (p_no_fire_hold) else $error("count moved idle");

   property p_start_after_last;
      @(posedge ref_clk) disable iff (!rstn)
      (ce && tvalid && tready && tlast) |=> (phase == pspm_pkg::PSPM_PH_START);
   endproperty
   a_start_after_last: assert property (p_start_after_last) else $error("no restart");

   property p_mid_no_pay;
      @(posedge ref_clk) disable iff (!rstn)
      (ce && !snap && phase == pspm_pkg::PSPM_PH_BODY) |=> $stable(pay_acc);
   endproperty
   a_mid_no_pay: assert property (p_mid_no_pay) else $error("payload counted mid packet");

   property p_acc_clear;
      @(posedge ref_clk) disable iff (!rstn)
      (ce && snap) |=> (raw_acc == `PSPM_CNT_RST) && (pay_acc == `PSPM_CNT_RST);
   endproperty
   a_acc_clear: assert property (p_acc_clear) else $error("accumulator not cleared");

endmodule

// ---- sim/pspm_stream_model.sv ----
// Behavioural source and destination pair for one stream direction.
`timescale 1ns/1ps
module pspm_stream_model (
   input  wire logic         ref_clk,
   output logic      [127:0] tdata,
   output logic              tlast,
   output logic              tvalid,
   output logic              tready
);
   logic slow_mode;

   initial begin
      tdata     = 128'h0;
      tlast     = 1'h0;
      tvalid    = 1'h0;
      tready    = 1'h1;
      slow_mode = 1'h0;
   end

   // ====================================================================
   // Ready gaps and idle data
   // Idle data flips every cycle so a stale beat can never look valid.
   always @(posedge ref_clk) begin
      #1;
      tready = slow_mode ? ~tready : 1'h1;
      if (tvalid == 1'h0) begin
         tdata = ~tdata;
      end
   end

   // ====================================================================
   // Packet source
   // Body beats carry a header-like pattern to expose payload decoded off a start beat.
   task automatic send(input logic [31:0] hdr, input int beats, input logic slow);
      int   b;
      logic taken;
      slow_mode = slow;
      for (b = 0; b < beats; b++) begin
         if (slow) begin
            tvalid = 1'h0;
            tlast  = 1'h0;
            @(posedge ref_clk);
            #1;
         end
         tdata  = (b == 0) ? {96'h5A5A_5A5A_5A5A_5A5A_5A5A_5A5A, hdr} : {4{32'h4000_0010}};
         tlast  = (b == beats - 1);
         tvalid = 1'h1;
         taken  = 1'h0;
         while (taken == 1'h0) begin
            @(posedge ref_clk);
            taken = tready;
            #1;
         end
      end
      tvalid    = 1'h0;
      tlast     = 1'h0;
      slow_mode = 1'h0;
      // One idle edge keeps a following call from raising valid in this time step.
      @(posedge ref_clk);
      #1;
   endtask
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the stream performance monitor.
`timescale 1ns/1ps
module tb;
   localparam int S = 64;
   typedef struct packed {
      logic [31:0] hdr;
      int          beats;
      logic        slow;
      logic [31:0] pay;
   } pspm_row_type;

   logic         ref_clk = 1'h0;
   logic         rstn    = 1'h0;
   logic         ce      = 1'h1;
   logic [127:0] tx_data;
   logic         tx_last;
   logic         tx_valid;
   logic         tx_ready;
   logic [127:0] rx_data;
   logic         rx_last;
   logic         rx_valid;
   logic         rx_ready;
   logic [31:0]  tx_raw;
   logic [31:0]  rx_raw;
   logic [31:0]  tx_pay;
   logic [31:0]  rx_pay;
   int           err_total = 0;
   int           checks    = 0;
   int           cycles    = 0;
   int unsigned  ccount    = 0;
   logic [1:0]   last_tag  = 2'h0;
   pspm_row_type rows [8] = '{
      '{32'h4000_0004, 2, 1'h0, 32'h0000_0010}, '{32'h4A00_0000, 4, 1'h1, 32'h0000_1000},
      '{32'h0000_0001, 1, 1'h0, 32'h0000_0000}, '{32'h0A00_0001, 1, 1'h1, 32'h0000_0000},
      '{32'h7000_0002, 3, 1'h0, 32'h0000_0000}, '{32'h6000_03FF, 2, 1'h1, 32'h0000_0FFC},
      '{32'h4000_0008, 2, 1'h0, 32'h0000_0020}, '{32'h4B00_0001, 1, 1'h0, 32'h0000_0000}};

   pspm_monitor #(.SECOND_CYCLES(S)) pspm_monitor_i (
      .ref_clk          (ref_clk),
      .rstn             (rstn),
      .ce               (ce),
      .s_axis_tx_tdata  (tx_data),
      .s_axis_tx_tlast  (tx_last),
      .s_axis_tx_tvalid (tx_valid),
      .s_axis_tx_tready (tx_ready),
      .m_axis_rx_tdata  (rx_data),
      .m_axis_rx_tlast  (rx_last),
      .m_axis_rx_tvalid (rx_valid),
      .m_axis_rx_tready (rx_ready),
      .tx_byte_count    (tx_raw),
      .rx_byte_count    (rx_raw),
      .tx_payload_count (tx_pay),
      .rx_payload_count (rx_pay)
   );
   pspm_stream_model tx_model (.ref_clk(ref_clk), .tdata(tx_data), .tlast(tx_last),
      .tvalid(tx_valid), .tready(tx_ready));
   pspm_stream_model rx_model (.ref_clk(ref_clk), .tdata(rx_data), .tlast(rx_last),
      .tvalid(rx_valid), .tready(rx_ready));

   // ====================================================================
   // Clock, period reference and timeout
   always #4 ref_clk = ~ref_clk;

   always @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         ccount <= 0;
      end else if (ce) begin
         ccount <= ccount + 1;
      end
   end

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         err_total++;
         tally_and_finish();
      end
   end

   // ====================================================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic check_outs(input logic [31:0] tr, input logic [31:0] rr,
                             input logic [31:0] tp, input logic [31:0] rp);
      logic [1:0] tag;
      tag = 2'((ccount / S) % 4);
      check(tx_raw, {tr[31:2], tag});
      check(rx_raw, {rr[31:2], tag});
      check(tx_pay, {tp[31:2], tag});
      check(rx_pay, {rp[31:2], tag});
      // A fresh reading must carry a tag that differs from the last one read.
      check(32'(tx_raw[1:0] != last_tag), 32'h1);
      last_tag = tx_raw[1:0];
   endtask

   // Refresh lands on the edge that completes a period; outputs are read just after it.
   task automatic to_boundary();
      do begin
         @(posedge ref_clk);
         #1;
      end while (ccount % S != 0);
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ====================================================================
   // Main sequence
   initial begin
      repeat (20) @(posedge ref_clk);
      #1;
      rstn = 1'h1;
      check(tx_raw | rx_raw | tx_pay | rx_pay, 32'h0);
      to_boundary();
      check_outs(32'h0, 32'h0, 32'h0, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         fork
            tx_model.send(rows[i].hdr, rows[i].beats, rows[i].slow);
            begin
               rx_model.send(rows[i].hdr, rows[i].beats, rows[i].slow);
               rx_model.send(rows[i].hdr, rows[i].beats, rows[i].slow);
            end
         join
         to_boundary();
         check_outs(32'(rows[i].beats * 16), 32'(rows[i].beats * 32),
                    rows[i].pay, rows[i].pay << 1);
         $display("test row %0d done", i);
      end
      // A frozen clock enable must hide beats and hold the period timer.
      ce = 1'h0;
      tx_model.send(32'h4000_0004, 2, 1'h0);
      repeat (4) @(posedge ref_clk);
      #1;
      ce = 1'h1;
      tx_model.send(32'h0000_0001, 1, 1'h0);
      to_boundary();
      check_outs(32'h10, 32'h0, 32'h0, 32'h0);
      $display("test clock enable done");
      // A reset in mid-period drops partial sums and restarts the tag.
      tx_model.send(32'h4000_0004, 2, 1'h0);
      rstn = 1'h0;
      @(posedge ref_clk);
      #1;
      check(tx_raw | rx_raw | tx_pay | rx_pay, 32'h0);
      repeat (2) @(posedge ref_clk);
      #1;
      rstn = 1'h1;
      to_boundary();
      check_outs(32'h0, 32'h0, 32'h0, 32'h0);
      $display("test mid reset done");
      tally_and_finish();
   end
endmodule
